// File: hrfplc_pkg.sv
// constants, types and offsets of the hid report command handler
// assumes an apb master on a single 25 MHz clock
// Summary of operation
// - report 0x43 out: one selection byte clears buffers
// - selection bit 0 flushes transmit, bit 1 receive; both self-clear
// - report 0x44 in: 16-bit actual pin levels, high byte first
// - read map: 14 status a, 8 status b, 5 rx, 4 tx, 15 and 9 zero, rest general
// - report 0x45 out: 16-bit state then 16-bit mask, high byte first
// - pin follows state only when output and mask bit set; else holds
// - write map: pins 9-6 at 13-10, 5-4 at 7-6, 3-0 at 3-0
// - report 0x46 in: product identifier low byte, then revision
// - report 0x47 in/out: 16-bit lock word, high byte first
// - writing zero locks a field until reset; no report unlocks it
// - writing all zeros locks every field
// - lock bits 15..7 and 3..0 name fields; 6:4 reserved
// - report 0x48: byte 1 bit 0 transmit wide mode, reset off
// - byte 2 bit 0 receive wide mode, reset off
// - byte 2 bit 1 low-latency receive, reset on
package hrfplc_pkg;
    // apb register byte addresses
    localparam logic [7:0]  A_CMD     = 8'h00;
    localparam logic [7:0]  A_OUT0    = 8'h04;
    localparam logic [7:0]  A_IN0     = 8'h08;
    localparam logic [7:0]  A_IN1     = 8'h0C;
    localparam logic [7:0]  A_STATUS  = 8'h10;
    localparam logic [7:0]  A_LOCK    = 8'h14;
    localparam logic [7:0]  A_PINOUT  = 8'h18;
    // report identifiers
    localparam logic [7:0]  ID_FLUSH  = 8'h43;
    localparam logic [7:0]  ID_PINRD  = 8'h44;
    localparam logic [7:0]  ID_PINWR  = 8'h45;
    localparam logic [7:0]  ID_VERS   = 8'h46;
    localparam logic [7:0]  ID_LOCK   = 8'h47;
    localparam logic [7:0]  ID_MODE   = 8'h48;
    // command and status register fields
    localparam int          CMD_GET_BIT   = 8;
    localparam int          ST_ERR_BIT    = 0;
    // field positions inside out0 (byte 1 at 31:24)
    localparam int          SEL_TX_BIT    = 24;
    localparam int          SEL_RX_BIT    = 25;
    localparam int          MODE_TXW_BIT  = 24;
    localparam int          MODE_RXW_BIT  = 16;
    localparam int          MODE_LLAT_BIT = 17;
    // reset values and valid lock field mask
    localparam logic [15:0] LOCK_RST      = 16'hFF8F;
    localparam logic [15:0] LOCK_VALID    = 16'hFF8F;
    localparam logic        TXW_RST       = 1'b0;
    localparam logic        RXW_RST       = 1'b0;
    localparam logic        LLAT_RST      = 1'b1;
    localparam logic [9:0]  PINOUT_RST    = 10'h000;

    typedef enum logic [1:0] {
        HRFPLC_IDLE = 2'b01,
        HRFPLC_DONE = 2'b10
    } hrfplc_apb_st_t;
endpackage

// File: hrfplc_pins_if.sv
// carrier between pin synchroniser and command core
// assumes both ends run on pclk
`timescale 1ns/1ps
interface hrfplc_pins_if;
    logic [15:0] raw;
    logic [15:0] level;
    modport sync (input raw, output level);
    modport core (output raw, input level);
endinterface

// File: hrfplc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes raw pin levels are asynchronous to pclk
`timescale 1ns/1ps
module hrfplc_pin_sync (
    // clock and reset
    input wire logic    pclk,
    input wire logic    presetn,
    // pins
    hrfplc_pins_if.sync pins
);
    logic [15:0] s1_r;
    logic [15:0] s2_r;
    logic [15:0] s3_r;
    logic [15:0] lvl_r;

    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_bit
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_r[i]  <= 1'b0;
                    s2_r[i]  <= 1'b0;
                    s3_r[i]  <= 1'b0;
                    lvl_r[i] <= 1'b0;
                end
                else
                begin
                    s1_r[i] <= pins.raw[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    // change accepted once stages two and three agree
                    if (s2_r[i] == s3_r[i])
                        lvl_r[i] <= s3_r[i];
                end
            end
        end
    endgenerate

    assign pins.level = lvl_r;
endmodule

// File: hrfplc_report_ctrl.sv
// hid report command handler: flush, pin state, version, lock, modes
// assumes an apb master on pclk; pin inputs are asynchronous
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module hrfplc_report_ctrl #(
    parameter logic [7:0] PRODUCT_ID_LOW = 8'h5A, // arbitrary value
    parameter logic [7:0] MFR_REVISION   = 8'h3C  // arbitrary value
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pin levels
    input  wire logic [9:0]  general_pin_in,
    input  wire logic        usb_status_pin_a,
    input  wire logic        usb_status_pin_b,
    input  wire logic        uart_rx_pin,
    input  wire logic        uart_tx_pin,
    // pin direction, 1 = output
    input  wire logic [9:0]  general_pin_dir,
    // pin drive
    output logic      [9:0]  general_pin_out,
    // fifo flush pulses
    output logic             flush_tx_fifo,
    output logic             flush_rx_fifo,
    // modes and lock
    output logic             tx_wide_mode,
    output logic             rx_wide_mode,
    output logic             rx_low_latency,
    output logic      [15:0] otp_lock_word
);
    hrfplc_pins_if pins_if ();

    hrfplc_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins_if.sync)
    );

    // pack raw pins at read positions, reserved 15 and 9 at zero
    assign pins_if.raw = {1'b0, usb_status_pin_a, general_pin_in[9:6], 1'b0,
                          usb_status_pin_b, general_pin_in[5:4], uart_rx_pin,
                          uart_tx_pin, general_pin_in[3:0]};

    hrfplc_pkg::hrfplc_apb_st_t st_r;
    hrfplc_pkg::hrfplc_apb_st_t st_nxt;

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [7:0]  last_id_r;
    logic        last_get_r;
    logic [31:0] out0_r;
    logic [31:0] in0_r;
    logic [31:0] in1_r;
    logic        err_r;
    logic [15:0] lock_r;
    logic        txw_r;
    logic        rxw_r;
    logic        llat_r;
    logic [9:0]  pin_out_r;
    logic        flush_tx_r;
    logic        flush_rx_r;

    // apb decode
    wire         access   = psel & penable;
    wire         st_done  = (st_r == hrfplc_pkg::HRFPLC_DONE);
    wire         hit_cmd  = (paddr == hrfplc_pkg::A_CMD);
    wire         hit_out0 = (paddr == hrfplc_pkg::A_OUT0);
    wire         hit_in0  = (paddr == hrfplc_pkg::A_IN0);
    wire         hit_in1  = (paddr == hrfplc_pkg::A_IN1);
    wire         hit_stat = (paddr == hrfplc_pkg::A_STATUS);
    wire         hit_lock = (paddr == hrfplc_pkg::A_LOCK);
    wire         hit_pout = (paddr == hrfplc_pkg::A_PINOUT);
    wire         addr_hit = hit_cmd | hit_out0 | hit_in0 | hit_in1 | hit_stat
                          | hit_lock | hit_pout;
    wire         commit   = st_done & access & pwrite & addr_hit;

    // command decode
    wire         cmd_wr   = commit & hit_cmd;
    wire [7:0]   cmd_id   = pwdata[7:0];
    wire         cmd_get  = pwdata[hrfplc_pkg::CMD_GET_BIT];
    wire         ex_flush = cmd_wr & ~cmd_get & (cmd_id == hrfplc_pkg::ID_FLUSH);
    wire         ex_pinrd = cmd_wr &  cmd_get & (cmd_id == hrfplc_pkg::ID_PINRD);
    wire         ex_pinwr = cmd_wr & ~cmd_get & (cmd_id == hrfplc_pkg::ID_PINWR);
    wire         ex_vers  = cmd_wr &  cmd_get & (cmd_id == hrfplc_pkg::ID_VERS);
    wire         ex_lockr = cmd_wr &  cmd_get & (cmd_id == hrfplc_pkg::ID_LOCK);
    wire         ex_lockw = cmd_wr & ~cmd_get & (cmd_id == hrfplc_pkg::ID_LOCK);
    wire         ex_moder = cmd_wr &  cmd_get & (cmd_id == hrfplc_pkg::ID_MODE);
    wire         ex_modew = cmd_wr & ~cmd_get & (cmd_id == hrfplc_pkg::ID_MODE);
    wire         ex_valid = ex_flush | ex_pinrd | ex_pinwr | ex_vers | ex_lockr
                          | ex_lockw | ex_moder | ex_modew;
    wire         ex_get   = ex_pinrd | ex_vers | ex_lockr | ex_moder;
    wire         err_clr  = commit & hit_stat & pwdata[hrfplc_pkg::ST_ERR_BIT];

    // pin write: state and mask, reserved positions dropped
    wire [15:0]  wr_state = out0_r[31:16];
    wire [15:0]  wr_mask  = out0_r[15:0];
    wire [9:0]   st10     = {wr_state[13:10], wr_state[7:6], wr_state[3:0]};
    wire [9:0]   mk10     = {wr_mask[13:10], wr_mask[7:6], wr_mask[3:0]};
    wire [9:0]   pin_sel  = mk10 & general_pin_dir;
    wire [9:0]   pin_nxt  = (pin_out_r & ~pin_sel) | (st10 & pin_sel);

    // lock word can only lose ones
    wire [15:0]  lock_nxt = lock_r & out0_r[31:16] & hrfplc_pkg::LOCK_VALID;

    // answer bytes, byte 1 at 31:24
    wire [15:0]  pin_word = pins_if.level & 16'h7DFF;
    wire [31:0]  ans0     = ex_pinrd ? {pin_word, 16'h0000} :
                            ex_vers  ? {PRODUCT_ID_LOW, MFR_REVISION, 16'h0000} :
                            ex_lockr ? {lock_r, 16'h0000} :
                                       {7'h00, txw_r, 6'h00, llat_r, rxw_r, 16'h0000};
    wire [31:0]  st_word  = {27'h0000000, llat_r, rxw_r, txw_r, 1'b0, err_r};

    // read mux
    wire [31:0]  rd_data  = hit_cmd  ? {23'h000000, last_get_r, last_id_r} :
                            hit_out0 ? out0_r :
                            hit_in0  ? in0_r :
                            hit_in1  ? in1_r :
                            hit_stat ? st_word :
                            hit_lock ? {16'h0000, lock_r} :
                            hit_pout ? {22'h000000, pin_out_r} : 32'h00000000;

    // apb handshake: one wait cycle, answer registered
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            hrfplc_pkg::HRFPLC_IDLE: if (access) st_nxt = hrfplc_pkg::HRFPLC_DONE;
            hrfplc_pkg::HRFPLC_DONE: st_nxt = hrfplc_pkg::HRFPLC_IDLE;
            default:                 st_nxt = hrfplc_pkg::HRFPLC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r      <= hrfplc_pkg::HRFPLC_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
        else
        begin
            st_r      <= st_nxt;
            pready_r  <= (st_r == hrfplc_pkg::HRFPLC_IDLE) & access;
            pslverr_r <= (st_r == hrfplc_pkg::HRFPLC_IDLE) & access & ~addr_hit;
            prdata_r  <= (access & ~pwrite) ? rd_data : 32'h00000000;
        end
    end

    // software registers and command effects
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_id_r  <= 8'h00;
            last_get_r <= 1'b0;
            out0_r     <= 32'h00000000;
            in0_r      <= 32'h00000000;
            in1_r      <= 32'h00000000;
            err_r      <= 1'b0;
        end
        else
        begin
            if (cmd_wr)
            begin
                last_id_r  <= cmd_id;
                last_get_r <= cmd_get;
            end
            if (commit & hit_out0)
                out0_r <= pwdata;
            if (ex_get)
            begin
                in0_r <= ans0;
                in1_r <= 32'h00000000;
            end
            // set wins over clear
            if (cmd_wr & ~ex_valid)
                err_r <= 1'b1;
            else if (err_clr)
                err_r <= 1'b0;
        end
    end

    // device state driven by reports
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flush_tx_r <= 1'b0;
            flush_rx_r <= 1'b0;
            pin_out_r  <= hrfplc_pkg::PINOUT_RST;
            lock_r     <= hrfplc_pkg::LOCK_RST;
            txw_r      <= hrfplc_pkg::TXW_RST;
            rxw_r      <= hrfplc_pkg::RXW_RST;
            llat_r     <= hrfplc_pkg::LLAT_RST;
        end
        else
        begin
            flush_tx_r <= ex_flush & out0_r[hrfplc_pkg::SEL_TX_BIT];
            flush_rx_r <= ex_flush & out0_r[hrfplc_pkg::SEL_RX_BIT];
            if (ex_pinwr)
                pin_out_r <= pin_nxt;
            if (ex_lockw)
                lock_r <= lock_nxt;
            if (ex_modew)
            begin
                txw_r  <= out0_r[hrfplc_pkg::MODE_TXW_BIT];
                rxw_r  <= out0_r[hrfplc_pkg::MODE_RXW_BIT];
                llat_r <= out0_r[hrfplc_pkg::MODE_LLAT_BIT];
            end
        end
    end

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;
    assign general_pin_out = pin_out_r;
    assign flush_tx_fifo   = flush_tx_r;
    assign flush_rx_fifo   = flush_rx_r;
    assign tx_wide_mode    = txw_r;
    assign rx_wide_mode    = rxw_r;
    assign rx_low_latency  = llat_r;
    assign otp_lock_word   = lock_r;

    // checks
    a_apb_answer_one: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one wait cycle");

    a_flush_tx_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (ex_flush && out0_r[24]) |=> flush_tx_fifo ##1 (!flush_tx_fifo || $past(ex_flush)))
        else $error("tx flush not a single pulse");

    a_flush_rx_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flush_rx_fifo) |-> $past(ex_flush && out0_r[25]))
        else $error("rx flush without report");

    a_pin_read_map: assert property (@(posedge pclk) disable iff (!presetn)
        ex_pinrd |=> (in0_r[31:16] == ($past(pins_if.level) & 16'h7DFF)))
        else $error("pin read value wrong");

    a_pin_read_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        ex_pinrd |=> (in0_r[31] == 1'b0 && in0_r[25] == 1'b0))
        else $error("reserved pin read bit set");

    a_pin_write_mask: assert property (@(posedge pclk) disable iff (!presetn)
        ex_pinwr |=> general_pin_out == (($past(general_pin_out) & ~$past(pin_sel))
                                        | ($past(st10) & $past(pin_sel))))
        else $error("masked pin write wrong");

    a_pin_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !ex_pinwr |=> $stable(general_pin_out))
        else $error("pin output changed without report");

    a_version_bytes: assert property (@(posedge pclk) disable iff (!presetn)
        ex_vers |=> (in0_r[31:24] == PRODUCT_ID_LOW && in0_r[23:16] == MFR_REVISION))
        else $error("version bytes wrong");

    a_lock_no_undo: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((otp_lock_word & ~$past(otp_lock_word)) == 16'h0000))
        else $error("lock bit returned to one");

    a_lock_all_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (ex_lockw && out0_r[31:16] == 16'h0000) |=> (otp_lock_word == 16'h0000))
        else $error("all-zero lock did not lock all");

    a_lock_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        otp_lock_word[6:4] == 3'h0)
        else $error("reserved lock bits set");

    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        ex_modew |=> (tx_wide_mode == $past(out0_r[24]) && rx_wide_mode == $past(out0_r[16])
                      && rx_low_latency == $past(out0_r[17])))
        else $error("mode write not applied");

    a_mode_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !ex_modew |=> $stable({tx_wide_mode, rx_wide_mode, rx_low_latency}))
        else $error("mode changed without report");

    a_err_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_wr && !ex_valid) |=> err_r)
        else $error("unknown report not flagged");
endmodule

// File: hrfplc_host_model.sv
// host model: issues hid reports to the command handler as apb transfers
// assumes the handler answers on pclk; a wait of 16 cycles or more raises hang
`timescale 1ns/1ps
module hrfplc_host_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // wait ran out
    output logic             hang
);
    initial
    begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        hang    = 1'h0;
    end

    // one transfer, request held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (n >= 16)
            hang <= 1'h1;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // set report: payload bytes high first, then the report id
    task automatic set_report(input logic [7:0] id, input logic [31:0] pay);
        logic [31:0] rd;
        logic        err;
        xfer(1'h1, hrfplc_pkg::A_OUT0, pay, rd, err);
        xfer(1'h1, hrfplc_pkg::A_CMD, {23'h0, 1'h0, id}, rd, err);
    endtask

    // get report: request by id, then fetch answer bytes 1..4
    task automatic get_report(input logic [7:0] id, output logic [31:0] ans);
        logic err;
        xfer(1'h1, hrfplc_pkg::A_CMD, {23'h0, 1'h1, id}, ans, err);
        xfer(1'h0, hrfplc_pkg::A_IN0, 32'h0, ans, err);
    endtask
endmodule

// File: tb_top.sv
// testbench: drives hid reports and pin levels, judges ports and answers
// assumes the host model for apb and a 25 MHz pclk
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    localparam logic [7:0] PID_LOW = 8'hA7; // arbitrary value
    localparam logic [7:0] REV     = 8'h1E; // arbitrary value
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hang;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0]  gp_in, gp_dir, gp_out, exp_out;
    logic        stat_a, stat_b, rx_pin, tx_pin, fl_tx, fl_rx, txw, rxw, llat;
    logic [15:0] lock_w;
    int          miscompares, num_checks, n_ftx, n_frx;

    hrfplc_host_model host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hang(hang));
    hrfplc_report_ctrl #(.PRODUCT_ID_LOW(PID_LOW), .MFR_REVISION(REV)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .general_pin_in(gp_in), .usb_status_pin_a(stat_a), .usb_status_pin_b(stat_b),
        .uart_rx_pin(rx_pin), .uart_tx_pin(tx_pin), .general_pin_dir(gp_dir),
        .general_pin_out(gp_out), .flush_tx_fifo(fl_tx), .flush_rx_fifo(fl_rx),
        .tx_wide_mode(txw), .rx_wide_mode(rxw), .rx_low_latency(llat), .otp_lock_word(lock_w));

    initial
    begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // count flush pulses
    always @(posedge pclk)
    begin
        if (fl_tx === 1'h1) n_ftx++;
        if (fl_rx === 1'h1) n_frx++;
    end

    always @(posedge pclk)
        if (hang === 1'h1)
        begin
            miscompares++;
            end_of_test();
        end

    task automatic end_of_test();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic t_reset();
        `CHK({txw, rxw, llat}, 3'h1)
        `CHK(lock_w, 16'hFF8F)
        `CHK({gp_out, fl_tx, fl_rx}, 12'h000)
    endtask

    task automatic t_flush();
        for (int s = 0; s < 4; s++)
        begin
            n_ftx = 0;
            n_frx = 0;
            host.set_report(hrfplc_pkg::ID_FLUSH, {6'h00, s[1:0], 24'h000000});
            repeat (4) @(posedge pclk);
            `CHK(n_ftx, s % 2)
            `CHK(n_frx, s / 2)
        end
    endtask

    task automatic t_pin_read(input logic [9:0] g, input logic [3:0] s);
        logic [31:0] ans;
        gp_in <= g;
        {stat_a, stat_b, rx_pin, tx_pin} <= s;
        repeat (8) @(posedge pclk);
        host.get_report(hrfplc_pkg::ID_PINRD, ans);
        `CHK(ans[31:16], {1'h0, s[3], g[9:6], 1'h0, s[2], g[5:4], s[1:0], g[3:0]})
    endtask

    task automatic t_pin_write(input logic [9:0] dir, input logic [15:0] st, input logic [15:0] mk);
        logic [9:0]  me;
        logic [31:0] rd;
        logic        err;
        me = {mk[13:10], mk[7:6], mk[3:0]} & dir;
        exp_out = ({st[13:10], st[7:6], st[3:0]} & me) | (exp_out & ~me);
        gp_dir <= dir;
        host.set_report(hrfplc_pkg::ID_PINWR, {st, mk});
        repeat (2) @(posedge pclk);
        `CHK(gp_out, exp_out)
        host.xfer(1'h0, hrfplc_pkg::A_PINOUT, 32'h0, rd, err);
        `CHK(rd[9:0], exp_out)
    endtask

    task automatic t_lock(input logic [15:0] v, input logic [15:0] exp);
        logic [31:0] ans;
        host.set_report(hrfplc_pkg::ID_LOCK, {v, 16'h0000});
        host.get_report(hrfplc_pkg::ID_LOCK, ans);
        `CHK(ans[31:16], exp)
        `CHK(lock_w, exp)
    endtask

    task automatic t_mode_ver();
        logic [31:0] ans;
        for (int m = 0; m < 8; m++)
        begin
            host.set_report(hrfplc_pkg::ID_MODE, {7'h00, m[2], 6'h00, m[1:0], 16'h0000});
            repeat (2) @(posedge pclk);
            `CHK({txw, llat, rxw}, m[2:0])
            host.get_report(hrfplc_pkg::ID_MODE, ans);
            `CHK({ans[24], ans[17], ans[16]}, m[2:0])
        end
        host.get_report(hrfplc_pkg::ID_VERS, ans);
        `CHK(ans[31:16], {PID_LOW, REV})
    endtask

    // unmapped address, unknown id, sticky error cleared by write one
    task automatic t_errors();
        logic [31:0] rd;
        logic        err;
        host.xfer(1'h0, 8'hFC, 32'h0, rd, err);
        `CHK({err, rd}, 33'h100000000)
        host.set_report(8'h50, 32'h0);
        host.xfer(1'h0, hrfplc_pkg::A_STATUS, 32'h0, rd, err);
        `CHK(rd[0], 1'h1)
        host.xfer(1'h1, hrfplc_pkg::A_STATUS, 32'h1, rd, err);
        host.xfer(1'h0, hrfplc_pkg::A_STATUS, 32'h0, rd, err);
        `CHK(rd[0], 1'h0)
    endtask

    initial
    begin
        presetn = 1'h0;
        gp_in = 10'h000;
        gp_dir = 10'h000;
        {stat_a, stat_b, rx_pin, tx_pin} = 4'h0;
        exp_out = 10'h000;
        miscompares = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_flush();
        t_pin_read(10'h3FF, 4'hF);
        t_pin_read(10'h2A5, 4'h5);
        t_pin_read(10'h15A, 4'hA);
        t_pin_write(10'h3FF, 16'hFFFF, 16'hFFFF);
        t_pin_write(10'h0F0, 16'h0000, 16'hFFFF);
        t_pin_write(10'h3FF, 16'h0000, 16'hC330);
        t_pin_write(10'h3FF, 16'h2481, 16'h3CCF);
        t_lock(16'hFFFE, 16'hFF8E);
        t_lock(16'h7FFF, 16'h7F8E);
        t_lock(16'hFFFF, 16'h7F8E);
        t_lock(16'h0000, 16'h0000);
        t_lock(16'hFFFF, 16'h0000);
        t_mode_ver();
        t_errors();
        end_of_test();
    end
endmodule
